/* pkg/mbd_regs.svh */
// Offsets, field positions, reset values and decode ranges of the module block decoder.
// Assumes byte addresses on a 24-bit processor bus with 16-bit data.
`ifndef MBD_REGS_SVH
`define MBD_REGS_SVH
`define MBD_BASE_REG_ADDR 24'h0000ee
`define MBD_BASE_REG_RESET 16'hbffe
`define MBD_SPACE_MSB 15
`define MBD_SPACE_LSB 13
`define MBD_CMP_BIT 12
`define MBD_BASE_MSB 11
`define MBD_BASE_LSB 0
`define MBD_IACK_SPACE 3'h7
`define MBD_BUS_LO 12'h000
`define MBD_BUS_HI 12'h00c
`define MBD_MEM_LO 12'h010
`define MBD_MEM_HI 12'h016
`define MBD_NET_LO 12'h800
`define MBD_NET_HI 12'h810
`define MBD_AMT_LO 12'ha00
`define MBD_AMT_HI 12'hbff
`define MBD_DT_LO 12'hc00
`define MBD_DT_HI 12'hfff
`define MBD_SUPER_BIT 2
`endif

/* pkg/mbd_pkg.sv */
// Types shared by the module block decoder files.
// Assumes nothing beyond a SystemVerilog compiler.
package mbd_pkg;
	typedef enum logic [2:0] {
		MBD_SEL_NONE,
		MBD_SEL_BUS,
		MBD_SEL_MEM,
		MBD_SEL_NET,
		MBD_SEL_AMT,
		MBD_SEL_DT
	} mbd_sel_type;
endpackage

/* rtl/mbd_range_decode.sv */
// Offset decoder that sorts a block offset into its sub-range.
// Assumes the caller qualifies the result with the block hit.
`include "mbd_regs.svh"
module mbd_range_decode (
	// Offset within the block
	input wire logic [11:0] offset,
	// Decoded target
	output mbd_pkg::mbd_sel_type sel
);
	// Register ranges take even words only; table ranges take any byte
	always_comb begin
		sel = mbd_pkg::MBD_SEL_NONE;
		if (offset >= `MBD_BUS_LO && offset <= `MBD_BUS_HI && !offset[0]) begin
			sel = mbd_pkg::MBD_SEL_BUS;
		end else if (offset >= `MBD_MEM_LO && offset <= `MBD_MEM_HI && !offset[0]) begin
			sel = mbd_pkg::MBD_SEL_MEM;
		end else if (offset >= `MBD_NET_LO && offset <= `MBD_NET_HI && !offset[0]) begin
			sel = mbd_pkg::MBD_SEL_NET;
		end else if (offset >= `MBD_AMT_LO && offset <= `MBD_AMT_HI) begin
			sel = mbd_pkg::MBD_SEL_AMT;
		end else if (offset >= `MBD_DT_LO) begin
			sel = mbd_pkg::MBD_SEL_DT;
		end
	end
endmodule

/* rtl/mbd_decoder.sv */
// Module block base register and block address decoder.
// Assumes bus inputs synchronous to REF_CLK; sub-range registers live elsewhere and
// answer through the SUB_ACK input; unanswered cycles end by an external bus timeout.
//
// Summary of operation
// - Base register sits at address 0x0EE
// - Base register resets to 0xBFFE
// - Base register writes need supervisor mode
// - Base bits 11-0 give address 23-12
// - Bits 15-13 hold the space code
// - Compare disabled: match on address only
// - Compare enabled: function code must match too
// - No acknowledge for unimplemented block offsets
// - Block registers are 16-bit, offsets 0x000-0xFFF
// - Offsets 0x000-0x00C select bus-control registers
// - Offsets 0x010-0x016 select memory-controller registers
// - Network registers, match table, descriptor table ranges
`include "mbd_regs.svh"
module mbd_decoder #(
	parameter int ADDR_W = 24
) (
	// Clock, reset, enable
	input wire logic REF_CLK,
	input wire logic ARST_N,
	input wire logic CLK_EN,
	// Processor bus
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [2:0] FC,
	input wire logic AS_N,
	input wire logic RD_WR_N,
	input wire logic [15:0] WDATA,
	// Sub-range answers
	input wire logic SUB_ACK,
	input wire logic [15:0] SUB_RDATA,
	// Selects toward sub-ranges
	output logic SEL_BUS,
	output logic SEL_MEM,
	output logic SEL_NET,
	output logic SEL_AMT,
	output logic SEL_DT,
	output logic [11:0] BLOCK_OFFSET,
	// Answer to the processor
	output logic [15:0] RDATA,
	output logic TRANSFER_ACKNOWLEDGE_STROBE_N,
	// Register view
	output logic [15:0] MODULE_BLOCK_BASE
);
	logic [15:0] module_block_base_r, module_block_base_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic ack_r, ack_nxt;
	logic as_d_r, as_d_nxt;
	logic [2:0] space_code_field;
	logic space_compare_enable;
	logic [11:0] module_base_field;
	logic base_addr_high_bit;
	logic reg_hit, block_hit, space_ok, supervisor, as_start;
	mbd_pkg::mbd_sel_type sel;

	// Field split of the base register
	assign space_code_field = module_block_base_r[`MBD_SPACE_MSB:`MBD_SPACE_LSB];
	assign space_compare_enable = module_block_base_r[`MBD_CMP_BIT];
	assign module_base_field = module_block_base_r[`MBD_BASE_MSB:`MBD_BASE_LSB];
	assign base_addr_high_bit = module_base_field[11];
	assign supervisor = FC[`MBD_SUPER_BIT];
	assign as_start = !AS_N && as_d_r;

	// Space check is skipped entirely when the compare enable is clear
	assign space_ok = !space_compare_enable || (FC == space_code_field);
	// Block hit: upper address equals base field during the address strobe
	assign block_hit = !AS_N && (ADDR[23:12] == module_base_field) && space_ok;
	assign reg_hit = !AS_N && (ADDR[23:0] == `MBD_BASE_REG_ADDR);
	assign BLOCK_OFFSET = ADDR[11:0];

	mbd_range_decode mbd_range_decode_inst (
		.offset(ADDR[11:0]),
		.sel(sel)
	);

	// Selects only while the block is hit
	assign SEL_BUS = block_hit && sel == mbd_pkg::MBD_SEL_BUS;
	assign SEL_MEM = block_hit && sel == mbd_pkg::MBD_SEL_MEM;
	assign SEL_NET = block_hit && sel == mbd_pkg::MBD_SEL_NET;
	assign SEL_AMT = block_hit && sel == mbd_pkg::MBD_SEL_AMT;
	assign SEL_DT = block_hit && sel == mbd_pkg::MBD_SEL_DT;

	// Next-state: base register write, read data and acknowledge
	always_comb begin
		module_block_base_nxt = module_block_base_r;
		rdata_nxt = rdata_r;
		ack_nxt = ack_r;
		as_d_nxt = AS_N;
		if (AS_N) begin
			ack_nxt = 1'b0;
		end else if (as_start && reg_hit) begin
			// User-mode writes are acknowledged but leave the value alone
			if (!RD_WR_N && supervisor) begin
				module_block_base_nxt = WDATA;
			end
			rdata_nxt = module_block_base_r;
			ack_nxt = 1'b1;
		end else if (block_hit && sel != mbd_pkg::MBD_SEL_NONE && SUB_ACK && !ack_r) begin
			rdata_nxt = SUB_RDATA;
			ack_nxt = 1'b1;
		end
		// Unimplemented offsets never reach the acknowledge
	end

	// Registers only; frozen while the clock enable is low
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			module_block_base_r <= `MBD_BASE_REG_RESET;
			rdata_r <= 16'h0000;
			ack_r <= 1'b0;
			as_d_r <= 1'b1;
		end else if (CLK_EN) begin
			module_block_base_r <= module_block_base_nxt;
			rdata_r <= rdata_nxt;
			ack_r <= ack_nxt;
			as_d_r <= as_d_nxt;
		end
	end

	assign RDATA = rdata_r;
	assign TRANSFER_ACKNOWLEDGE_STROBE_N = !ack_r;
	assign MODULE_BLOCK_BASE = module_block_base_r;

	// Assertions
	a_user_write_blocked: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		CLK_EN && as_start && reg_hit && !RD_WR_N && !supervisor
		|=> $stable(module_block_base_r))
		else $error("user mode write changed base register");
	a_super_write_taken: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		CLK_EN && as_start && reg_hit && !RD_WR_N && supervisor
		|=> module_block_base_r == $past(WDATA))
		else $error("supervisor write not stored");
	a_no_ack_unmapped: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		CLK_EN && block_hit && sel == mbd_pkg::MBD_SEL_NONE && !reg_hit && !ack_r
		|=> !ack_r)
		else $error("acknowledge for unimplemented offset");
	a_space_ignored: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		!AS_N && !space_compare_enable && ADDR[23:12] == module_base_field
		|-> block_hit)
		else $error("hit lost with compare disabled");
	a_space_checked: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		space_compare_enable && FC != space_code_field |-> !block_hit)
		else $error("hit with wrong function code");
	a_hit_needs_strobe: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		AS_N |-> !block_hit && !SEL_BUS && !SEL_NET)
		else $error("hit without address strobe");
	a_bus_range: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		SEL_BUS |-> ADDR[11:0] <= 12'h00c && !ADDR[0])
		else $error("bus select outside range");
	a_mem_range: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		block_hit && ADDR[11:0] == 12'h012 |-> SEL_MEM)
		else $error("memory select missed");
	a_table_range: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		block_hit && ADDR[11:0] == 12'hc01 |-> SEL_DT && !SEL_AMT)
		else $error("descriptor table select missed");
	a_ack_ends: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		CLK_EN && AS_N |=> !ack_r)
		else $error("acknowledge outlived strobe");
	// Two sub-ranges selected at once would put two drivers on the read data
	a_sel_one_hot: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		$onehot0({SEL_BUS, SEL_MEM, SEL_NET, SEL_AMT, SEL_DT}))
		else $error("more than one sub-range selected");
	a_net_range: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		SEL_NET |-> ADDR[11:0] >= 12'h800 && ADDR[11:0] <= 12'h810 && !ADDR[0])
		else $error("network select outside range");
	a_base_reg_ack: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		CLK_EN && as_start && reg_hit |=> !TRANSFER_ACKNOWLEDGE_STROBE_N)
		else $error("base register access not acknowledged");
endmodule

/* bench/mbd_sub_model.sv */
// Sub-range registers behind the module block decoder.
// Assumes the selects stay up while the address strobe is held.
module mbd_sub_model (
	// Decoder side
	input wire logic [4:0] sel,
	input wire logic [11:0] off,
	output logic ack,
	output logic [15:0] data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] last_r = 16'h0000;
	logic [3:0] tag;
	// Read word names the select that answered, so a wrong sub-range shows up
	always_comb begin
		ack = |sel;
		case (sel)
			5'h01: tag = 4'h1;
			5'h02: tag = 4'h2;
			5'h04: tag = 4'h3;
			5'h08: tag = 4'h4;
			5'h10: tag = 4'h5;
			default: tag = 4'hf;
		endcase
		data = ack ? {tag, off} : ~last_r;
	end
	// Remember the word last driven
	always @(data) if (ack) last_r = data;
endmodule

/* bench/mbd_decoder_test.sv */
// Self-checking bench for the module block decoder.
// Assumes mbd_sub_model answers every select at once.
module mbd_decoder_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rst_n = 1'b0, as_n = 1'b1, rw = 1'b1, sack, ack_n, ack_q = 1'b1;
	logic [23:0] addr = 24'h000000;
	logic [2:0] fc = 3'h5;
	logic [15:0] wd = 16'h0000, rd, base, sd;
	logic [4:0] sel;
	logic [11:0] off, bf;
	logic [15:0] expq[$];
	int n_mismatch = 0, cmp_count = 0, cyc = 0;
	logic [11:0] offs[13] = '{12'h000, 12'h00c, 12'h010, 12'h016, 12'h800, 12'h810,
		12'ha00, 12'hbff, 12'hc00, 12'hfff, 12'h00e, 12'h018, 12'h900};
	// Expected select code per offset: bus, memory, network, match table, descriptors
	logic [3:0] ids[10] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h4, 4'h5, 4'h5};
	// 40 MHz clock
	always #12.5 clk = ~clk;
	mbd_decoder mbd_decoder_inst (.REF_CLK(clk), .ARST_N(rst_n), .CLK_EN(1'b1),
		.ADDR(addr), .FC(fc), .AS_N(as_n), .RD_WR_N(rw), .WDATA(wd), .SUB_ACK(sack),
		.SUB_RDATA(sd), .SEL_BUS(sel[0]), .SEL_MEM(sel[1]), .SEL_NET(sel[2]),
		.SEL_AMT(sel[3]), .SEL_DT(sel[4]), .BLOCK_OFFSET(off), .RDATA(rd),
		.TRANSFER_ACKNOWLEDGE_STROBE_N(ack_n), .MODULE_BLOCK_BASE(base));
	mbd_sub_model mbd_sub_model_inst (.sel(sel), .off(off), .ack(sack), .data(sd));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t saw %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// One strobed cycle; a miss must stay unanswered for the whole wait
	task automatic acc(input logic [23:0] a, input logic [2:0] f, input logic w,
		input logic [15:0] d, input logic hit);
		@(negedge clk);
		addr = a;
		fc = f;
		rw = ~w;
		wd = d;
		as_n = 1'b0;
		for (int i = 0; i < 8 && ack_n !== 1'b0; i++) @(negedge clk);
		chk({15'h0000, ack_n}, {15'h0000, ~hit});
		as_n = 1'b1;
		repeat (2) @(negedge clk);
	endtask
	// Oldest note is compared on the first cycle of each read answer
	always @(negedge clk) begin
		if (ack_n === 1'b0 && ack_q === 1'b1 && rw === 1'b1 && expq.size() > 0)
			chk(rd, expq.pop_front());
		ack_q <= ack_n;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc > 3000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	// Main sequence
	initial begin
		void'($urandom(93781));
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		chk(base, 16'hbffe);
		expq.push_back(16'hbffe);
		acc(24'h0000ee, 3'h5, 1'b0, 16'h0000, 1'b1);
		acc(24'h0000ee, 3'h1, 1'b1, 16'h1234, 1'b1);
		chk(base, 16'hbffe);
		// Nonzero base keeps the block clear of the base register; space never 111
		bf = 12'($urandom_range(4095, 1));
		acc(24'h0000ee, 3'h5, 1'b1, {3'h5, 1'b0, bf}, 1'b1);
		chk(base, {3'h5, 1'b0, bf});
		offs[6] = 12'ha00 + 12'($urandom_range(511));
		offs[9] = 12'hc00 + 12'($urandom_range(1023));
		for (int k = 0; k < 13; k++) begin
			if (k < 10)
				expq.push_back({ids[k], offs[k]});
			acc({bf, offs[k]}, 3'h1, 1'b0, 16'h0000, k < 10);
		end
		acc({bf ^ 12'h001, 12'h002}, 3'h5, 1'b0, 16'h0000, 1'b0);
		acc(24'h0000ee, 3'h5, 1'b1, {3'h5, 1'b1, bf}, 1'b1);
		acc({bf, 12'h002}, 3'h1, 1'b0, 16'h0000, 1'b0);
		expq.push_back(16'h1002);
		acc({bf, 12'h002}, 3'h5, 1'b0, 16'h0000, 1'b1);
		// Every noted read must have been answered
		chk(16'(expq.size()), 16'h0000);
		end_of_test();
	end
endmodule
